// ---- design/ccr_pkg.sv ----
// Package with the register map, field layout and constants of the card control registers.
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register indices and bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned CCR_AW = 16;
  localparam logic [CCR_AW-1:0] CCR_IDX_BOARD_COMMAND = 16'h0064;
  localparam logic [CCR_AW-1:0] CCR_IDX_KERNEL_VERSION = 16'h04ba;
  localparam logic [CCR_AW-1:0] CCR_IDX_CUSTOM_CODES = 16'h0c3a;
  localparam logic [CCR_AW-1:0] CCR_IDX_CHANNEL_SELECT = 16'h2af8;
  localparam logic [CCR_AW-1:0] CCR_IDX_CHANNEL_TOTAL = 16'h2af9;
  localparam logic [CCR_AW-1:0] CCR_IDX_STATUS = 16'h2afa;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned CCR_VER_MAJOR_LSB = 24;
  localparam int unsigned CCR_VER_MINOR_LSB = 16;
  localparam int unsigned CCR_VER_BUILD_LSB = 0;
  localparam int unsigned CCR_CM_BASE_LSB = 0;
  localparam int unsigned CCR_CM_FRONT_LSB = 8;
  localparam int unsigned CCR_CM_SYNC_LSB = 16;
  localparam int unsigned CCR_MAX_CH = 4;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CCR_FULL_BOARD_RESET_CMD = 32'h0000_0001;
  localparam logic [CCR_MAX_CH-1:0] CCR_CHSEL_RESET = 4'h1;
  localparam logic [2:0] CCR_CHTOTAL_RESET = 3'h1;
  localparam logic [3:0] CCR_SOFT_RESET_CYCLES = 4'h8;

  // Status word bit positions.
  localparam int unsigned CCR_ST_VALUE_ERR = 0;
  localparam int unsigned CCR_ST_RESET_BUSY = 1;
  localparam int unsigned CCR_ST_MEM_VALID = 2;

  typedef enum logic [1:0] {
    CCR_ST_IDLE,
    CCR_ST_RESET,
    CCR_ST_RUN
  } ccr_state_e;

endpackage

// ---- design/ccr_card_control_registers.sv ----
// Card control register bank: version, custom codes, board command and channel selection.
//
// Summary of operation
// - Kernel version word: major in bits 31:24, minor 23:16, build 15:0.
// - Kernel version reads the driver version in use; writes are ignored.
// - Custom codes: base in byte 0, front-end byte 1, sync module byte 2.
// - Custom codes read zero on a standard build.
// - Command register is write-only; reset command starts a full board reset.
// - Command reset acts on hardware exactly like power-on reset, except that the read port keeps working and board_reset_busy is raised.
// - After command reset every setting holds its default.
// - Command reset marks sample memory contents invalid.
// - Command reset disables trigger and clock outputs until reconfigured.
// - Channel bitmap: bit n enables output channel n, combined by OR.
// - A new mask applies only when the next generation run starts.
// - Only the listed masks for 1, 2 or 4 channel cards are accepted.
// - An illegal mask raises a value error and keeps the old setting.
// - Bits of channels not fitted are never accepted for NUM_CH of 1 or 2; any other NUM_CH uses the 4-channel table.
// - Sample memory is shared among enabled channels only.
// - Reading the bitmap returns the most recently accepted mask.
// - Channel total returns the set-bit count of the accepted mask.
`timescale 1ns/100ps
`default_nettype none

module ccr_card_control_registers
  import ccr_pkg::*;
#(
  parameter int unsigned NUM_CH = 4,
  parameter int unsigned MEM_AW = 30,
  parameter logic [7:0] VER_MAJOR = 8'h01,
  parameter logic [7:0] VER_MINOR = 8'h00,
  parameter logic [15:0] VER_BUILD = 16'h0001,
  // Custom codes are arbitrary; zero marks a standard build.
  parameter logic [7:0] CM_BASE = 8'h00,
  parameter logic [7:0] CM_FRONT = 8'h00,
  parameter logic [7:0] CM_SYNC = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [CCR_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Run control
  input wire logic run_start,
  input wire logic run_stop,
  // Auxiliary output configuration and memory load
  input wire logic aux_trig_en_set,
  input wire logic aux_clk_en_set,
  input wire logic mem_load_done,
  // Block outputs
  output logic [CCR_MAX_CH-1:0] run_channel_mask,
  output logic [MEM_AW-1:0] mem_per_channel,
  output logic running,
  output logic trig_out_en,
  output logic clk_out_en,
  output logic mem_valid,
  output logic board_reset_busy,
  output logic value_err
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [CCR_MAX_CH-1:0] chsel_r;
  logic [2:0] chtotal_r;
  logic [3:0] rst_cnt_r;
  ccr_state_e state_r;
  logic soft_rst;
  logic mask_ok;
  logic [2:0] pop_nxt;
  logic [CCR_MAX_CH-1:0] wmask;
  logic cmd_wr;
  logic chsel_wr;

  assign wmask = reg_wdata[CCR_MAX_CH-1:0];
  assign cmd_wr = reg_wr && (reg_addr == CCR_IDX_BOARD_COMMAND);
  assign chsel_wr = reg_wr && (reg_addr == CCR_IDX_CHANNEL_SELECT);
  // While state_r is CCR_ST_RESET every setting and output except the read port and board_reset_busy is held as under power-on reset.
  assign soft_rst = (state_r == CCR_ST_RESET);

  // ----------------------------------------------------------------
  // Mask check
  // ----------------------------------------------------------------
  // Only 1, 2 or 4 set bits form a legal mask, inside the fitted channels for
  // NUM_CH of 1 or 2 and inside the low four bits for any other NUM_CH.
  always_comb begin
    mask_ok = 1'b0;
    if (reg_wdata[31:CCR_MAX_CH] == '0) begin
      unique case (NUM_CH)
        1: mask_ok = (wmask == 4'h1);
        2: mask_ok = (wmask == 4'h1) || (wmask == 4'h2) || (wmask == 4'h3);
        default: mask_ok = (wmask != 4'h0) && (wmask != 4'h7) && (wmask != 4'hb) &&
          (wmask != 4'hd) && (wmask != 4'he);
      endcase
    end
  end

  always_comb begin
    pop_nxt = 3'h0;
    for (int i = 0; i < CCR_MAX_CH; i++) begin
      pop_nxt = pop_nxt + {2'b00, wmask[i]};
    end
  end

  // ----------------------------------------------------------------
  // Board reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= CCR_ST_IDLE;
      rst_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        CCR_ST_IDLE, CCR_ST_RUN: begin
          if (cmd_wr && reg_wdata == CCR_FULL_BOARD_RESET_CMD) begin
            state_r <= CCR_ST_RESET;
            rst_cnt_r <= CCR_SOFT_RESET_CYCLES;
          end else if (state_r == CCR_ST_IDLE && run_start) begin
            state_r <= CCR_ST_RUN;
          end else if (state_r == CCR_ST_RUN && run_stop) begin
            state_r <= CCR_ST_IDLE;
          end
        end
        CCR_ST_RESET: begin
          rst_cnt_r <= rst_cnt_r - 4'h1;
          if (rst_cnt_r == 4'h1) begin
            state_r <= CCR_ST_IDLE;
          end
        end
        default: state_r <= CCR_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chsel_r <= CCR_CHSEL_RESET;
      chtotal_r <= CCR_CHTOTAL_RESET;
      value_err <= 1'b0;
    end else if (soft_rst) begin
      chsel_r <= CCR_CHSEL_RESET;
      chtotal_r <= CCR_CHTOTAL_RESET;
      value_err <= 1'b0;
    end else if (chsel_wr) begin
      if (mask_ok) begin
        chsel_r <= wmask;
        chtotal_r <= pop_nxt;
        value_err <= 1'b0;
      end else begin
        value_err <= 1'b1;
      end
    end
  end

  // A mask takes hold only at the start of a run, so a write during a
  // run cannot disturb the channels being generated.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_channel_mask <= CCR_CHSEL_RESET;
      mem_per_channel <= '1;
      running <= 1'b0;
    end else if (soft_rst) begin
      run_channel_mask <= CCR_CHSEL_RESET;
      mem_per_channel <= '1;
      running <= 1'b0;
    end else begin
      if (state_r == CCR_ST_IDLE && run_start && !cmd_wr) begin
        run_channel_mask <= chsel_r;
        // Power-of-two totals make the share a plain shift.
        unique case (chtotal_r)
          3'h4: mem_per_channel <= {2'b00, {(MEM_AW-2){1'b1}}};
          3'h2: mem_per_channel <= {1'b0, {(MEM_AW-1){1'b1}}};
          default: mem_per_channel <= '1;
        endcase
        running <= 1'b1;
      end else if (state_r == CCR_ST_RUN && run_stop) begin
        running <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary outputs and memory validity
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_out_en <= 1'b0;
      clk_out_en <= 1'b0;
      mem_valid <= 1'b0;
      board_reset_busy <= 1'b0;
    end else begin
      board_reset_busy <= (state_r == CCR_ST_RESET) ||
        (cmd_wr && reg_wdata == CCR_FULL_BOARD_RESET_CMD);
      if (soft_rst) begin
        trig_out_en <= 1'b0;
        clk_out_en <= 1'b0;
        mem_valid <= 1'b0;
      end else begin
        if (aux_trig_en_set) begin
          trig_out_en <= 1'b1;
        end
        if (aux_clk_en_set) begin
          clk_out_en <= 1'b1;
        end
        if (mem_load_done) begin
          mem_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CCR_IDX_KERNEL_VERSION: begin
          reg_rdata <= (32'(VER_MAJOR) << CCR_VER_MAJOR_LSB) |
            (32'(VER_MINOR) << CCR_VER_MINOR_LSB) |
            (32'(VER_BUILD) << CCR_VER_BUILD_LSB);
        end
        CCR_IDX_CUSTOM_CODES: begin
          reg_rdata <= (32'(CM_BASE) << CCR_CM_BASE_LSB) |
            (32'(CM_FRONT) << CCR_CM_FRONT_LSB) |
            (32'(CM_SYNC) << CCR_CM_SYNC_LSB);
        end
        CCR_IDX_CHANNEL_SELECT: reg_rdata <= {28'h0000000, chsel_r};
        CCR_IDX_CHANNEL_TOTAL: reg_rdata <= {29'h00000000, chtotal_r};
        CCR_IDX_STATUS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[CCR_ST_VALUE_ERR] <= value_err;
          reg_rdata[CCR_ST_RESET_BUSY] <= board_reset_busy;
          reg_rdata[CCR_ST_MEM_VALID] <= mem_valid;
        end
        CCR_IDX_BOARD_COMMAND: reg_rdata <= 32'h0000_0000;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ---- dv/ccr_monitor.sv ----
// Concurrent checks on the ports of the card control register bank.
`timescale 1ns/100ps
`default_nettype none
module ccr_monitor
  import ccr_pkg::*;
#(
  parameter logic [7:0] VER_MAJOR = 8'h01,
  parameter logic [7:0] VER_MINOR = 8'h00,
  parameter logic [15:0] VER_BUILD = 16'h0001,
  parameter logic [7:0] CM_BASE = 8'h00,
  parameter logic [7:0] CM_FRONT = 8'h00,
  parameter logic [7:0] CM_SYNC = 8'h00
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [CCR_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic run_start,
  input wire logic [CCR_MAX_CH-1:0] run_channel_mask,
  input wire logic running,
  input wire logic trig_out_en,
  input wire logic clk_out_en,
  input wire logic mem_valid,
  input wire logic board_reset_busy,
  input wire logic value_err
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // A mask is legal with one, two or four of the four low bits set.
  function automatic logic legal(logic [31:0] d);
    return d[31:4] == 28'h0 && $countones(d[3:0]) inside {1, 2, 4};
  endfunction
  logic sel_wr;
  logic cmd_wr;
  assign sel_wr = reg_wr && reg_addr == CCR_IDX_CHANNEL_SELECT && !board_reset_busy;
  assign cmd_wr = reg_wr && reg_addr == CCR_IDX_BOARD_COMMAND;
  version_read_a: assert property (reg_rd && reg_addr == CCR_IDX_KERNEL_VERSION |=>
    reg_rdata == {VER_MAJOR, VER_MINOR, VER_BUILD}) else $error("version word wrong");
  custom_read_a: assert property (reg_rd && reg_addr == CCR_IDX_CUSTOM_CODES |=>
    reg_rdata == {8'h00, CM_SYNC, CM_FRONT, CM_BASE}) else $error("custom codes wrong");
  cmd_read_zero_a: assert property (reg_rd && reg_addr == CCR_IDX_BOARD_COMMAND |=>
    reg_rdata == 32'h0) else $error("command read not zero");
  reset_start_a: assert property (cmd_wr && reg_wdata == CCR_FULL_BOARD_RESET_CMD |=>
    board_reset_busy) else $error("reset command not started");
  busy_length_a: assert property ($rose(board_reset_busy) |->
    ##8 board_reset_busy ##1 !board_reset_busy) else $error("reset busy length wrong");
  reset_defaults_a: assert property ($fell(board_reset_busy) |->
    run_channel_mask == CCR_CHSEL_RESET && !trig_out_en && !clk_out_en && !mem_valid
    && !running && !value_err) else $error("settings not default after reset");
  mask_refuse_a: assert property (sel_wr && !legal(reg_wdata) |=> value_err)
    else $error("illegal mask not refused");
  mask_accept_a: assert property (sel_wr && legal(reg_wdata) |=> !value_err)
    else $error("legal mask refused");
  run_hold_a: assert property (running && !board_reset_busy && !cmd_wr |=>
    $stable(run_channel_mask) || board_reset_busy) else $error("run mask changed in run");
endmodule
bind ccr_card_control_registers ccr_monitor #(.VER_MAJOR(VER_MAJOR), .VER_MINOR(VER_MINOR),
  .VER_BUILD(VER_BUILD), .CM_BASE(CM_BASE), .CM_FRONT(CM_FRONT), .CM_SYNC(CM_SYNC)) i_mon (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_start(run_start),
  .run_channel_mask(run_channel_mask), .running(running), .trig_out_en(trig_out_en),
  .clk_out_en(clk_out_en), .mem_valid(mem_valid), .board_reset_busy(board_reset_busy),
  .value_err(value_err));
`default_nettype wire

// ---- dv/ccr_card_control_registers_tb.sv ----
// Self-checking bench of the card control register bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module ccr_card_control_registers_tb;
  import ccr_pkg::*;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, run_start = 0, run_stop = 0;
  logic aux_trig_en_set = 0, aux_clk_en_set = 0, mem_load_done = 0;
  logic [CCR_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [3:0] run_channel_mask;
  logic [29:0] mem_per_channel;
  logic running, trig_out_en, clk_out_en, mem_valid, board_reset_busy, value_err;
  int fail_count = 0, n_compared = 0, cyc = 0, sel_m = 1, err_m = 0;
  ccr_card_control_registers #(.VER_MINOR(8'h0b), .VER_BUILD(16'h0331)) i_dut (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_start(run_start), .run_stop(run_stop),
    .aux_trig_en_set(aux_trig_en_set), .aux_clk_en_set(aux_clk_en_set),
    .mem_load_done(mem_load_done), .run_channel_mask(run_channel_mask),
    .mem_per_channel(mem_per_channel), .running(running), .trig_out_en(trig_out_en),
    .clk_out_en(clk_out_en), .mem_valid(mem_valid), .board_reset_busy(board_reset_busy),
    .value_err(value_err));
  always #12.5 clk = ~clk;
  task automatic conclude();
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    run_start <= k == 0;
    run_stop <= k == 1;
    {aux_trig_en_set, aux_clk_en_set, mem_load_done} <= {3{k == 2}};
    @(posedge clk);
    {run_start, run_stop, aux_trig_en_set, aux_clk_en_set, mem_load_done} <= 5'h0;
    @(posedge clk);
    #1;
  endtask
  task automatic check_sel();
    rd(CCR_IDX_CHANNEL_SELECT, sel_m, "chsel");
    rd(CCR_IDX_CHANNEL_TOTAL, $countones(sel_m), "total");
    `CHK("value_err", err_m[0], value_err)
  endtask
  task automatic set_sel(input int v);
    int c;
    c = $countones(v);
    wr(CCR_IDX_CHANNEL_SELECT, v);
    err_m = !(v > 0 && v < 16 && (c == 1 || c == 2 || c == 4));
    if (!err_m) sel_m = v;
    check_sel();
  endtask
  initial begin
    void'($urandom(16));
    repeat (10) @(posedge clk);
    resetn <= 1;
    wr(CCR_IDX_BOARD_COMMAND, 32'h1);
    repeat (12) @(posedge clk);
    rd(CCR_IDX_KERNEL_VERSION, 32'h010b0331, "version");
    wr(CCR_IDX_KERNEL_VERSION, 32'hffffffff);
    rd(CCR_IDX_KERNEL_VERSION, 32'h010b0331, "version");
    rd(CCR_IDX_CUSTOM_CODES, 32'h0, "custom");
    rd(CCR_IDX_BOARD_COMMAND, 32'h0, "command");
    check_sel();
    for (int i = 0; i < 16; i++) set_sel(i);
    repeat (6) set_sel($urandom);
    set_sel(3);
    pulse(0);
    `CHK("run_mask", 4'h3, run_channel_mask)
    `CHK("mem_share", 30'h1fffffff, mem_per_channel)
    set_sel(8);
    `CHK("run_mask", 4'h3, run_channel_mask)
    pulse(1);
    pulse(0);
    `CHK("run_mask", 4'h8, run_channel_mask)
    pulse(2);
    set_sel(7);
    rd(CCR_IDX_STATUS, 32'h5, "status");
    wr(CCR_IDX_BOARD_COMMAND, 32'h2);
    #1 `CHK("busy", 1'b0, board_reset_busy)
    `CHK("trig_en", 1'b1, trig_out_en)
    wr(CCR_IDX_BOARD_COMMAND, 32'h1);
    #1 `CHK("busy", 1'b1, board_reset_busy)
    wr(CCR_IDX_CHANNEL_SELECT, 32'h2);
    for (int i = 0; i < 20 && board_reset_busy !== 1'b0; i++) @(posedge clk);
    #1 `CHK("busy", 1'b0, board_reset_busy)
    `CHK("aux_en", 3'h0, {trig_out_en, clk_out_en, running})
    `CHK("mem_valid", 1'b0, mem_valid)
    `CHK("run_mask", 4'h1, run_channel_mask)
    sel_m = 1;
    err_m = 0;
    check_sel();
    conclude();
  end
endmodule
`default_nettype wire
